/* File: pkg/dram_seq_defs.vh */
// Constants for the DRAM access sequencer
`ifndef DRAM_SEQ_DEFS_VH
`define DRAM_SEQ_DEFS_VH

// Sequencer state field, bit3..bit0
`define ST_IDLE         4'h0
`define ST_ACC_BEGIN    4'h4
`define ST_ACC_COLUMN   4'h6
`define ST_READ_BEAT    4'h2
`define ST_WRITE_ONE    4'he
`define ST_WRITE_TWO    4'hc
`define ST_WRITE_THREE  4'h7
`define ST_REF_BEGIN    4'h8
`define ST_REF_ACTIVE   4'h9
`define ST_REF_END      4'hb
`define ST_WIND_DOWN    4'h1
`define ST_POWER_UP     4'hf
`define ST_ILLEGAL_1    4'h3
`define ST_ILLEGAL_2    4'h5
`define ST_ILLEGAL_3    4'ha
`define ST_ILLEGAL_4    4'hd

// RAM window: address bits 29..22 all zero
`define RAM_SEL_HI      29
`define RAM_SEL_LO      22
`define RAM_SEL_MATCH   8'h00

// Cycle status codes for interrupt acknowledge / internal register
`define CS_INTACK       3'h3
`define CS_IPR          3'h2

// Burst type from latched address bits 31..30
`define BURST_LONG      2'h0
`define BURST_QUAD      2'h2
`define BURST_HEX       2'h1
`define BURST_OCTA      2'h3

// Last-beat value of the column flip count for each burst
`define LAST_LONG       2'h1
`define LAST_QUAD       2'h2
`define LAST_HEX        2'h3
`define LAST_OCTA       2'h0

// Precharge dwell per state
`define CLK_PERIOD_NS   8
`define PRECHARGE_NS    50
`define PRECHARGE_CYC   ((`PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Refresh address counter
`define REF_ADDR_W      10
`define REF_ADDR_RST    10'h000

`endif

/* File: rtl/dram_access_sequencer.v */
// DRAM address decoder and access/refresh sequencer
`timescale 1ns/1ps
`include "dram_seq_defs.vh"
//
// Contract
// - RAM selected only when address bits 29..22 are all zero.
// - Selects captured on rising edge of the address strobe.
// - Intack/IPR is read-with-status 011, or status 010.
// - Both selects cleared when strobe drops while either select held.
// - Parity/cache drivers enabled by data strobe during RAM cycle.
// - All state and burst flag bits run on the phase A clock.
// - Idle 0000, access_begin 0100, access_column 0110.
// - Read_beat 0010, wind_down 0001, power-up 1111.
// - Write beats encode 1110, 1100, 0111.
// - Refresh states encode 1000, 1001, 1011.
// - Codes 0011, 0101, 1010, 1101 are illegal and return toward idle.
// - Refresh arbitrated against access; row/column/address strobes ordered.
// - Late phase flag times the ready assertion.
// - Latched write picks write branch, else read branch.
// - No access starts during an interrupt acknowledge cycle.
// - Address bits 31..30 give burst length; 10 is a quadword read.
// - Column flip outputs fed back to find the last longword.
// - Power reset runs refresh cycles continuously.
// - System reset request forces idle and clears the strobe, refresh, flip and ready outputs.
// - Refresh cycle drives refresh address; its end advances the counter.
// - Access starts only with strobe and select, no intack, no refresh.
// - Every cycle not cut short by a system reset request ends through wind_down then idle, each a precharge.

module dram_access_sequencer #(
  parameter REF_W    = `REF_ADDR_W,
  parameter DWELL    = `PRECHARGE_CYC
) (
  // Clock and reset
  input  wire             sys_clk_in,
  input  wire             nrst_in,
  // Processor bus
  input  wire             addr_strobe_in,
  input  wire             data_strobe_in,
  input  wire             write_in,
  input  wire [7:0]       data_address_lines_in,
  input  wire [2:0]       cycle_status_lines_in,
  input  wire             synced_addr_strobe_in,
  input  wire             late_phase_flag_in,
  input  wire             latched_write_in,
  input  wire [1:0]       latched_address_in,
  // Reset and refresh control
  input  wire             power_reset_in,
  input  wire             system_reset_request_in,
  input  wire             refresh_request_in,
  // Decoder outputs
  output reg              ram_select_out,
  output reg              intack_or_ipr_cycle_out,
  output reg              parity_cache_drive_enable_out,
  // DRAM and ready outputs
  output reg              row_strobe_out,
  output reg              column_strobe_enable_out,
  output reg              refresh_cycle_active_out,
  output reg              col_bit2_flip_out,
  output reg              col_bit3_flip_out,
  output reg              memory_ready_out,
  output reg [REF_W-1:0]  refresh_addr_out
);

  //////////////////////////////////////////////////////////////////////////
  // Address and cycle status decoder

  reg  as_prev_reg;
  wire as_rise;
  wire cycle_select_clear;
  wire ram_hit;
  wire intack_hit;
  reg  ram_sel_next;
  reg  intack_next;

  assign as_rise = addr_strobe_in & ~as_prev_reg;
  assign ram_hit = (data_address_lines_in == `RAM_SEL_MATCH);
  assign intack_hit =
    (~write_in & (cycle_status_lines_in == `CS_INTACK)) |
    (cycle_status_lines_in == `CS_IPR);
  assign cycle_select_clear = ~addr_strobe_in &
    (ram_select_out | intack_or_ipr_cycle_out);

  always @* begin
    ram_sel_next = ram_select_out;
    intack_next  = intack_or_ipr_cycle_out;
    if (cycle_select_clear) begin
      ram_sel_next = 1'b0;
      intack_next  = 1'b0;
    end else if (as_rise) begin
      ram_sel_next = ram_hit;
      intack_next  = intack_hit;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      as_prev_reg                   <= 1'b0;
      ram_select_out                <= 1'b0;
      intack_or_ipr_cycle_out       <= 1'b0;
      parity_cache_drive_enable_out <= 1'b0;
    end else begin
      as_prev_reg                   <= addr_strobe_in;
      ram_select_out                <= ram_sel_next;
      intack_or_ipr_cycle_out       <= intack_next;
      parity_cache_drive_enable_out <= data_strobe_in & ram_sel_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Flip count value reached after the last beat of the burst
  function [1:0] last_count;
    input [1:0] burst;
    begin
      case (burst)
        `BURST_LONG: last_count = `LAST_LONG;
        `BURST_QUAD: last_count = `LAST_QUAD;
        `BURST_HEX:  last_count = `LAST_HEX;
        default:     last_count = `LAST_OCTA;
      endcase
    end
  endfunction

  reg  [3:0] state_reg;
  reg  [3:0] state_next;
  reg        flag_reg;
  reg        flag_next;
  reg  [7:0] dwell_reg;
  reg        ras_next;
  reg        cas_next;
  reg        refc_next;
  reg        inv2_next;
  reg        inv3_next;
  reg        rdy_next;
  wire       refresh_due;
  wire       mem_access;
  wire       dwell_done;
  wire [1:0] flip_count;
  wire [1:0] flip_step;
  wire       last_beat;

  assign refresh_due = refresh_request_in | power_reset_in;
  assign mem_access  = synced_addr_strobe_in & ram_select_out &
                       ~intack_or_ipr_cycle_out;
  assign dwell_done  = (dwell_reg >= DWELL - 1);
  assign flip_count  = {col_bit3_flip_out, col_bit2_flip_out};
  assign flip_step   = flip_count + 2'h1;
  assign last_beat   = (flip_count == last_count(latched_address_in));

  always @* begin
    state_next = state_reg;
    flag_next  = flag_reg;
    ras_next   = row_strobe_out;
    cas_next   = column_strobe_enable_out;
    refc_next  = refresh_cycle_active_out;
    inv2_next  = col_bit2_flip_out;
    inv3_next  = col_bit3_flip_out;
    rdy_next   = memory_ready_out;
    case (state_reg)
      `ST_IDLE: begin
        ras_next  = 1'b0;
        cas_next  = 1'b0;
        refc_next = 1'b0;
        inv2_next = 1'b0;
        inv3_next = 1'b0;
        rdy_next  = 1'b0;
        flag_next = 1'b0;
        if (dwell_done && refresh_due) begin
          state_next = `ST_REF_BEGIN;
          refc_next  = 1'b1;
          cas_next   = 1'b1;
        end else if (dwell_done && mem_access) begin
          state_next = `ST_ACC_BEGIN;
          ras_next   = 1'b1;
        end
      end
      `ST_ACC_BEGIN: begin
        if (mem_access && data_strobe_in) begin
          state_next = `ST_ACC_COLUMN;
          cas_next   = 1'b1;
        end else if (!mem_access) begin
          state_next = `ST_REF_END;
        end
      end
      `ST_ACC_COLUMN: begin
        if (late_phase_flag_in &&
            (latched_write_in || !flag_reg || !data_strobe_in)) begin
          rdy_next   = 1'b1;
          cas_next   = 1'b0;
          inv2_next  = flip_step[0];
          inv3_next  = flip_step[1];
          state_next = latched_write_in ? `ST_WRITE_ONE
                                        : `ST_READ_BEAT;
        end
      end
      `ST_READ_BEAT: begin
        rdy_next = 1'b0;
        if (mem_access && !last_beat) begin
          state_next = `ST_ACC_COLUMN;
          cas_next   = 1'b1;
          flag_next  = 1'b1;
        end else begin
          state_next = `ST_WIND_DOWN;
          ras_next   = 1'b0;
          cas_next   = 1'b0;
          inv2_next  = 1'b0;
          inv3_next  = 1'b0;
          flag_next  = 1'b0;
        end
      end
      `ST_WRITE_ONE: begin
        rdy_next = 1'b0;
        if (mem_access && !last_beat) begin
          state_next = `ST_WRITE_TWO;
        end else begin
          state_next = `ST_WIND_DOWN;
          ras_next   = 1'b0;
          cas_next   = 1'b0;
          inv2_next  = 1'b0;
          inv3_next  = 1'b0;
          flag_next  = 1'b0;
        end
      end
      `ST_WRITE_TWO: begin
        if (!data_strobe_in)
          state_next = `ST_WRITE_THREE;
      end
      `ST_WRITE_THREE: begin
        if (data_strobe_in) begin
          state_next = `ST_ACC_COLUMN;
          cas_next   = 1'b1;
          flag_next  = 1'b1;
        end
      end
      `ST_REF_BEGIN: begin
        state_next = `ST_REF_ACTIVE;
        ras_next   = 1'b1;
      end
      `ST_REF_ACTIVE: begin
        state_next = `ST_REF_END;
        cas_next   = 1'b0;
      end
      `ST_REF_END: begin
        state_next = `ST_WIND_DOWN;
        refc_next  = 1'b0;
        ras_next   = 1'b0;
      end
      `ST_WIND_DOWN: begin
        ras_next  = 1'b0;
        cas_next  = 1'b0;
        refc_next = 1'b0;
        inv2_next = 1'b0;
        inv3_next = 1'b0;
        rdy_next  = 1'b0;
        flag_next = 1'b0;
        if (dwell_done)
          state_next = `ST_IDLE;
      end
      default: begin
        state_next = `ST_WIND_DOWN;
        ras_next   = 1'b0;
        cas_next   = 1'b0;
        refc_next  = 1'b0;
        inv2_next  = 1'b0;
        inv3_next  = 1'b0;
        rdy_next   = 1'b0;
        flag_next  = 1'b0;
      end
    endcase
    if (system_reset_request_in) begin
      state_next = `ST_IDLE;
      ras_next   = 1'b0;
      cas_next   = 1'b0;
      refc_next  = 1'b0;
      inv2_next  = 1'b0;
      inv3_next  = 1'b0;
      rdy_next   = 1'b0;
      flag_next  = 1'b0;
    end
  end

  // State, flag and outputs all on the one clock
  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      state_reg                <= `ST_POWER_UP;
      flag_reg                 <= 1'b0;
      dwell_reg                <= 8'h00;
      row_strobe_out           <= 1'b0;
      column_strobe_enable_out <= 1'b0;
      refresh_cycle_active_out <= 1'b0;
      col_bit2_flip_out        <= 1'b0;
      col_bit3_flip_out        <= 1'b0;
      memory_ready_out         <= 1'b0;
      refresh_addr_out         <= `REF_ADDR_RST;
    end else begin
      state_reg                <= state_next;
      flag_reg                 <= flag_next;
      if (state_next != state_reg)
        dwell_reg <= 8'h00;
      else if (!dwell_done)
        dwell_reg <= dwell_reg + 8'h01;
      row_strobe_out           <= ras_next;
      column_strobe_enable_out <= cas_next;
      refresh_cycle_active_out <= refc_next;
      col_bit2_flip_out        <= inv2_next;
      col_bit3_flip_out        <= inv3_next;
      memory_ready_out         <= rdy_next;
      if (refresh_cycle_active_out && !refc_next)
        refresh_addr_out <= refresh_addr_out + 1'b1;
    end
  end

endmodule // dram_access_sequencer

/* File: tb/dram_refresh_source.sv */
// Refresh request source standing in for the external refresh counter
`timescale 1ns/1ps
//////////////////////////////
module dram_refresh_source (
  // Clock and reset
  input  wire sys_clk_in,
  input  wire nrst_in,
  // Trigger and acknowledge
  input  wire fire_in,
  input  wire refresh_cycle_active_in,
  // Request to the sequencer
  output reg  refresh_request_out = 1'b0
);
  reg fire_d_reg = 1'b0;
  always @(posedge sys_clk_in) begin
    fire_d_reg <= fire_in;
    if (!nrst_in)
      refresh_request_out <= 1'b0;
    else if (refresh_cycle_active_in)
      refresh_request_out <= 1'b0;
    else if (fire_in && !fire_d_reg)
      refresh_request_out <= 1'b1;
  end
endmodule  // dram_refresh_source

/* File: tb/dram_seq_checker.sv */
// Port assertions for the DRAM access sequencer
`timescale 1ns/1ps
//////////////////////////////
module dram_seq_checker (
  // Clock and reset
  input wire       sys_clk_in,
  input wire       nrst_in,
  // Watched inputs
  input wire       addr_strobe_in,
  input wire       data_strobe_in,
  input wire       write_in,
  input wire [7:0] data_address_lines_in,
  input wire [2:0] cycle_status_lines_in,
  input wire       synced_addr_strobe_in,
  input wire       late_phase_flag_in,
  input wire       latched_write_in,
  input wire       power_reset_in,
  input wire       system_reset_request_in,
  input wire       refresh_request_in,
  // Watched outputs
  input wire       ram_select_out,
  input wire       intack_or_ipr_cycle_out,
  input wire       parity_cache_drive_enable_out,
  input wire       row_strobe_out,
  input wire       column_strobe_enable_out,
  input wire       refresh_cycle_active_out,
  input wire       col_bit2_flip_out,
  input wire       col_bit3_flip_out,
  input wire       memory_ready_out
);
  reg may_start_reg = 1'b0;
  always @(posedge sys_clk_in)
    may_start_reg <= synced_addr_strobe_in && ram_select_out &&
      !intack_or_ipr_cycle_out && !refresh_request_in && !power_reset_in;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  a_ram_window: assert property (
    addr_strobe_in && !$past(addr_strobe_in) |=>
    ram_select_out == ($past(data_address_lines_in) == 8'h00))
    else $error("ram select wrong");
  a_intack_decode: assert property (
    addr_strobe_in && !$past(addr_strobe_in) |=> intack_or_ipr_cycle_out ==
    ($past(cycle_status_lines_in) == 3'h2 ||
    ($past(cycle_status_lines_in) == 3'h3 && !$past(write_in))))
    else $error("intack select wrong");
  a_parity_enable: assert property (
    parity_cache_drive_enable_out == ($past(data_strobe_in) && ram_select_out))
    else $error("parity enable wrong");
  a_ready_phase: assert property (
    $rose(memory_ready_out) |-> $past(late_phase_flag_in)
    ##1 !memory_ready_out) else $error("ready timing wrong");
  a_access_start: assert property (
    $rose(row_strobe_out) && !refresh_cycle_active_out |-> may_start_reg)
    else $error("access start wrong");
  a_refresh_shape: assert property (
    $rose(refresh_cycle_active_out) |-> column_strobe_enable_out &&
    !row_strobe_out ##1 row_strobe_out ##1 refresh_cycle_active_out &&
    !column_strobe_enable_out ##1 !refresh_cycle_active_out && !row_strobe_out)
    else $error("refresh shape wrong");
  a_sys_reset: assert property (
    system_reset_request_in |=> !row_strobe_out && !column_strobe_enable_out
    && !refresh_cycle_active_out && !memory_ready_out && !col_bit2_flip_out
    && !col_bit3_flip_out) else $error("reset request ignored");
  a_wind_down: assert property (
    $fell(row_strobe_out) |->
    (!row_strobe_out && !column_strobe_enable_out && !memory_ready_out)[*3])
    else $error("precharge too short");
  c_refresh: cover property ($rose(refresh_cycle_active_out));
  c_burst: cover property ($rose(col_bit3_flip_out));
  c_write: cover property ($rose(memory_ready_out) && latched_write_in);
endmodule  // dram_seq_checker
bind dram_access_sequencer dram_seq_checker u_chk (.*);

/* File: tb/dram_access_sequencer_bench.sv */
// Self-checking bench for the DRAM access sequencer
`timescale 1ns/1ps
//////////////////////////////
module dram_access_sequencer_bench;
  reg        sys_clk_in = 1'b0;
  reg        nrst_in = 1'b0;
  reg        addr_strobe_in = 1'b0;
  reg        data_strobe_in = 1'b0;
  reg        write_in = 1'b0;
  reg  [7:0] data_address_lines_in = 8'h00;
  reg  [2:0] cycle_status_lines_in = 3'h4;
  reg        synced_addr_strobe_in = 1'b0;
  reg        late_phase_flag_in = 1'b0;
  reg        latched_write_in = 1'b0;
  reg  [1:0] latched_address_in = 2'h0;
  reg        power_reset_in = 1'b0;
  reg        system_reset_request_in = 1'b0;
  reg        fire = 1'b0;
  reg [15:0] lfsr = 16'h0034;
  reg  [7:0] addr;
  reg        iack_exp;
  wire       refresh_request_in;
  wire       ram_select_out, intack_or_ipr_cycle_out;
  wire       parity_cache_drive_enable_out, row_strobe_out;
  wire       column_strobe_enable_out, refresh_cycle_active_out;
  wire       col_bit2_flip_out, col_bit3_flip_out, memory_ready_out;
  wire [9:0] refresh_addr_out;
  integer    bad_count = 0;
  integer    n_tests = 0;
  integer    cyc = 0;
  integer    ref_cnt = 0;
  integer    i, j, got, hold;
  dram_access_sequencer #(.DWELL(2)) u_dut (.*);
  dram_refresh_source u_ref (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .fire_in(fire), .refresh_cycle_active_in(refresh_cycle_active_out),
    .refresh_request_out(refresh_request_in));
  initial forever #4 sys_clk_in = ~sys_clk_in;
  // Four processor phases, high in the late two; hang guard
  always @(negedge sys_clk_in) begin
    cyc = cyc + 1;
    late_phase_flag_in <= cyc[1];
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end
  task complete_run;
    begin
      if (bad_count == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: %h %h", $time, seen, exp);
      end
    end
  endtask
  task step(input integer n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  function [15:0] nxt(input [15:0] v);
    nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function integer beats(input [1:0] la);
    beats = (la == 2'h2) ? 2 : (la == 2'h1) ? 3 : (la == 2'h3) ? 4 : 1;
  endfunction
  task strobe(input [7:0] a, input [2:0] cs, input wr);
    begin
      @(negedge sys_clk_in);
      data_address_lines_in = a;
      cycle_status_lines_in = cs;
      write_in = wr;
      addr_strobe_in = 1'b1;
      step(2);
    end
  endtask
  // One processor access, counting ready beats
  task access(input lw, input [1:0] la, input [2:0] cs, input integer n);
    begin
      latched_write_in = lw;
      latched_address_in = la;
      fire = (cs == 3'h5);
      strobe(8'h00, cs, lw);
      synced_addr_strobe_in = 1'b1;
      data_strobe_in = 1'b1;
      got = 0;
      hold = 0;
      for (j = 0; j < 60; j = j + 1) begin
        step(1);
        if (memory_ready_out === 1'b1) begin
          got = got + 1;
          data_strobe_in = 1'b0;
          hold = 2;
        end else if (got == n && n > 0) begin
          addr_strobe_in = 1'b0;
          synced_addr_strobe_in = 1'b0;
        end else if (hold > 0) begin
          hold = hold - 1;
          data_strobe_in = (hold == 0) && lw;
        end
      end
      check(got, n);
      check(row_strobe_out, 1'b0);
      addr_strobe_in = 1'b0;
      synced_addr_strobe_in = 1'b0;
      data_strobe_in = 1'b0;
      fire = 1'b0;
      step(8);
    end
  endtask
  initial begin
    step(2);
    nrst_in = 1'b1;
    step(10);
    for (i = 0; i < 16; i = i + 1) begin
      lfsr = nxt(lfsr);
      addr = lfsr[8] ? lfsr[7:0] : 8'h00;
      iack_exp = (!i[3] && i[2:0] == 3'h3) || i[2:0] == 3'h2;
      strobe(addr, i[2:0], i[3]);
      check(ram_select_out, addr == 8'h00);
      check(intack_or_ipr_cycle_out, iack_exp);
      data_strobe_in = 1'b1;
      step(2);
      check(parity_cache_drive_enable_out, addr == 8'h00);
      addr_strobe_in = 1'b0;
      data_strobe_in = 1'b0;
      step(2);
      check({ram_select_out, intack_or_ipr_cycle_out}, 2'h0);
    end
    fire = 1'b1;
    step(1);
    fire = 1'b0;
    step(14);
    ref_cnt = ref_cnt + 1;
    check(refresh_addr_out, ref_cnt);
    for (i = 0; i < 8; i = i + 1)
      access(i[2], i[1:0], 3'h4, beats(i[1:0]));
    access(1'b0, 2'h3, 3'h5, 4);
    ref_cnt = ref_cnt + 1;
    check(refresh_addr_out, ref_cnt);
    access(1'b0, 2'h0, 3'h3, 0);
    access(1'b1, 2'h0, 3'h2, 0);
    latched_address_in = 2'h3;
    strobe(8'h00, 3'h4, 1'b0);
    synced_addr_strobe_in = 1'b1;
    data_strobe_in = 1'b1;
    step(4);
    system_reset_request_in = 1'b1;
    step(2);
    check({row_strobe_out, column_strobe_enable_out, memory_ready_out,
      col_bit2_flip_out, col_bit3_flip_out}, 5'h00);
    addr_strobe_in = 1'b0;
    synced_addr_strobe_in = 1'b0;
    data_strobe_in = 1'b0;
    system_reset_request_in = 1'b0;
    step(8);
    power_reset_in = 1'b1;
    step(40);
    check(refresh_addr_out >= ref_cnt + 2, 1'b1);
    power_reset_in = 1'b0;
    complete_run;
  end
endmodule  // dram_access_sequencer_bench
